// ===== hw/bos_operand_shift_register.sv
`timescale 1ns/1ps
// ====================================================================
// How it works
// - Register is 16 bits, parallel data comes from the result mux.
// - Register changes only on the processor clock edge, or at once on asynchronous reset.
// - Both mode inputs high loads; control word bit 04 upper, 05 lower.
// - Lower-only shifts toward LSB, upper-only toward MSB, none holds.
// - Serial inputs matter only while shifting, not on load or hold.
// - Left shift fills bit 00, right shift fills bit 15.
// - Serial source: zero, bit 15, or carry, chosen by instruction.
// - One common serial source feeds whichever shift direction runs.
// - Control word bit 16 steers low byte, bit 14 steers high byte.
// - Both byte controls high pass the whole register unchanged.
// - Low control only passes low byte and copies bit 07 upward.
// - Both byte controls low give constant one, ignoring contents.
// - Bus is active low; constant one drives bit 00 low, rest high.
// - Upper byte mux outputs all high when low control is low.
// - Low nibble picks +1 or bits 00-03; bits 04-07 gated.
// - Active-low inhibit decides whether constant one is produced.
// - Register holds results read through the scratch memory path.
// - Sign extension of the low byte is offered on the bus.
// - Constant one serves increments and decrements by one.
// - Right shifts feed bit 08 into bit 07 through a separate path.
// - Rotates shift in the carry held before the instruction.
module bos_operand_shift_register
  import bos_pkg::*;
#(
  parameter int CS_W = BOS_CS_W
)
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [CS_W-1:0] i_cs_word,
  input wire bos_word_t i_result_mux,
  input wire bos_shift_op_e i_shift_op,
  input wire logic i_carry_flag,
  input wire logic i_plus_one_inhibit_n,
  output bos_word_t o_operand_shift_register,
  output bos_word_t o_b_operand_bus_n
);

  // ==================================================================
  // Control store field extraction
  bos_mode_s mode;
  bos_leg_s leg;
  bos_reg_op_e reg_op;

  // Mode pair and byte controls sit at fixed control word bits
  always_comb
  begin
    mode.mode_upper = i_cs_word[BOS_CS_MODE_UPPER];
    mode.mode_lower = i_cs_word[BOS_CS_MODE_LOWER];
    leg.upper_byte_select = i_cs_word[BOS_CS_UPPER_BYTE];
    leg.lower_byte_enable = i_cs_word[BOS_CS_LOWER_BYTE];
    leg.plus_one_inhibit_n = i_plus_one_inhibit_n;
  end

  assign reg_op = bos_decode_op(mode);

  // ==================================================================
  // Serial source selection
  logic serial_shift_in;
  logic low_byte_right_in;
  logic left_serial_in;
  logic right_serial_in;
  bos_word_t operand_q;
  bos_word_t operand_d;

  // The carry input is the flag flop output, so at the shift edge it
  // still shows the value from before the instruction
  always_comb
  begin
    case (i_shift_op)
      BOS_ARITHMETIC_SHIFT_LEFT: serial_shift_in = 1'b0;
      BOS_ARITHMETIC_SHIFT_RIGHT: serial_shift_in = operand_q[BOS_MSB];
      BOS_ROTATE_LEFT: serial_shift_in = i_carry_flag;
      BOS_ROTATE_RIGHT: serial_shift_in = i_carry_flag;
      default: serial_shift_in = 1'b0;
    endcase
  end

  // One source feeds both ends; only the active direction uses it
  assign left_serial_in = serial_shift_in;
  assign right_serial_in = serial_shift_in;

  // Halves have no direct right path, so bit 08 is routed explicitly
  assign low_byte_right_in = operand_q[BOS_LINK_BIT];

  // ==================================================================
  // Next register value
  always_comb
  begin
    case (reg_op)
      BOS_LOAD:
        operand_d = i_result_mux;
      BOS_SHIFT_RIGHT:
        operand_d = {right_serial_in,
          operand_q[BOS_MSB:BOS_LINK_BIT+1],
          low_byte_right_in,
          operand_q[BOS_SIGN_BIT:1]};
      BOS_SHIFT_LEFT:
        operand_d = {operand_q[BOS_MSB-1:0], left_serial_in};
      BOS_HOLD:
        operand_d = operand_q;
      default:
        operand_d = operand_q;
    endcase
  end

  // ==================================================================
  // Operand register
  // The rising edge of i_clk stands for the inverted processor clock;
  // hold keeps the contents as an inhibited clock would
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      operand_q <= BOS_REG_RST;
    else
      operand_q <= operand_d;
  end

  assign o_operand_shift_register = operand_q;

  // ==================================================================
  // B operand bus shaping
  bos_word_t leg_bus_n;
  bos_word_t b_bus_n_q;

  // Shaping reads only the register outputs, never writes them
  bos_leg_shaper u_leg_shaper (
    .i_reg(operand_q),
    .i_leg(leg),
    .o_bus_n(leg_bus_n)
  );

  // Registered so the ALU sees a clean bus; costs one cycle of latency
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      b_bus_n_q <= BOS_BUS_RST_N;
    else
      b_bus_n_q <= leg_bus_n;
  end

  assign o_b_operand_bus_n = b_bus_n_q;

  // ==================================================================
  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  // Step shapes shared by the shift and hold checks
  sequence right_shift_s;
    reg_op == BOS_SHIFT_RIGHT;
  endsequence

  sequence left_shift_s;
    reg_op == BOS_SHIFT_LEFT;
  endsequence

  sequence hold_twice_s;
    (reg_op == BOS_HOLD) [*2];
  endsequence

  property load_p;
    (mode.mode_upper && mode.mode_lower)
      |=> (operand_q == $past(i_result_mux));
  endproperty

  property right_p;
    right_shift_s |=> operand_q[BOS_MSB-1:BOS_LINK_BIT]
      == $past(operand_q[BOS_MSB:BOS_LINK_BIT+1])
      && operand_q[BOS_SIGN_BIT-1:0]
      == $past(operand_q[BOS_SIGN_BIT:1]);
  endproperty

  property left_p;
    left_shift_s |=> operand_q[BOS_MSB:1]
      == $past(operand_q[BOS_MSB-1:0]);
  endproperty

  // Parallel load takes the result mux word whole
  load_word_a: assert property (load_p)
    else $error("load did not take result mux word");

  // Right shift moves each byte's bits one place toward the LSB; the bit 08 to 07 link is checked below
  shift_right_a: assert property (right_p)
    else $error("right shift moved bits wrongly");

  // Left shift moves every bit one place toward the MSB
  shift_left_a: assert property (left_p)
    else $error("left shift moved bits wrongly");

  // Two holds in a row leave contents alone whatever the serial source
  hold_stable_a: assert property (
    hold_twice_s |=> operand_q == $past(operand_q, 2))
    else $error("register changed during hold");

  // The bit 08 to bit 07 link on a right shift
  byte_link_a: assert property (
    right_shift_s |=> operand_q[BOS_SIGN_BIT]
      == $past(operand_q[BOS_LINK_BIT]))
    else $error("bit 08 did not reach bit 07");

  // Serial fill of bit 15 on right shifts, per instruction
  right_fill_a: assert property (
    right_shift_s |=> operand_q[BOS_MSB]
      == (($past(i_shift_op) == BOS_ARITHMETIC_SHIFT_RIGHT)
      ? $past(operand_q[BOS_MSB])
      : ($past(i_shift_op) == BOS_ARITHMETIC_SHIFT_LEFT)
      ? 1'b0 : $past(i_carry_flag)))
    else $error("wrong serial fill on right shift");

  // Rotate left shifts in the carry that stood before the edge
  rotate_carry_a: assert property (
    (left_shift_s ##0 (i_shift_op == BOS_ROTATE_LEFT))
      |=> operand_q[0] == $past(i_carry_flag))
    else $error("rotate left lost old carry");

  // Arithmetic left shift fills bit 00 with zero
  shift_zero_a: assert property (
    (left_shift_s ##0 (i_shift_op == BOS_ARITHMETIC_SHIFT_LEFT))
      |=> operand_q[0] == 1'b0)
    else $error("arithmetic left shift filled a one");

  // Full word mode shows the register inverted on the bus next cycle
  leg_full_a: assert property (
    (leg.lower_byte_enable && leg.upper_byte_select)
      |=> o_b_operand_bus_n == ~$past(operand_q))
    else $error("full word not passed unchanged");

  // Sign extension copies bit 07 into the high byte
  leg_sign_a: assert property (
    (leg.lower_byte_enable && !leg.upper_byte_select)
      |=> o_b_operand_bus_n == ~{{BOS_BYTE_W{$past(
      operand_q[BOS_SIGN_BIT])}},
      $past(operand_q[BOS_BYTE_W-1:0])})
    else $error("sign extension wrong");

  // Constant one: bit 00 low, all else high, whatever is stored
  plus_one_a: assert property (
    (!leg.lower_byte_enable && leg.plus_one_inhibit_n)
      |=> o_b_operand_bus_n == 16'hFFFE)
    else $error("constant one pattern wrong");

  // Inhibited constant one leaves the whole bus high
  plus_inhibit_a: assert property (
    (!leg.lower_byte_enable && !leg.plus_one_inhibit_n)
      |=> o_b_operand_bus_n == 16'hFFFF)
    else $error("inhibit did not suppress constant one");

  // Bus mode changes never disturb the stored word during hold
  shape_isolated_a: assert property (
    (reg_op == BOS_HOLD && $changed(leg))
      |=> $stable(operand_q))
    else $error("bus mode altered register");

  // Register output tracks the internal state with no extra stage
  output_track_a: assert property (
    (reg_op == BOS_LOAD) |=> o_operand_shift_register
      == $past(i_result_mux))
    else $error("register output not the loaded word");

  // ==================================================================
  // Serial source and bus gating checks
  sequence load_s;
    reg_op == BOS_LOAD;
  endsequence

  sequence hold_s;
    reg_op == BOS_HOLD;
  endsequence

  sequence low_off_s;
    !leg.lower_byte_enable;
  endsequence

  sequence low_on_s;
    leg.lower_byte_enable;
  endsequence

  // A single hold keeps the word even with a serial source present
  hold_keep_a: assert property (
    hold_s |=> $stable(operand_q))
    else $error("register moved during hold");

  // A loaded word survives a following hold untouched
  load_then_hold_a: assert property (
    (load_s ##1 hold_s) |=> operand_q == $past(i_result_mux, 2))
    else $error("loaded word lost after hold");

  // Arithmetic right shift copies the old sign bit back into bit 15
  asr_sign_a: assert property (
    (right_shift_s ##0 (i_shift_op == BOS_ARITHMETIC_SHIFT_RIGHT))
      |=> operand_q[BOS_MSB] == $past(operand_q[BOS_MSB]))
    else $error("arithmetic right shift lost sign");

  // Rotate right brings the carry from before the edge into bit 15
  ror_carry_a: assert property (
    (right_shift_s ##0 (i_shift_op == BOS_ROTATE_RIGHT))
      |=> operand_q[BOS_MSB] == $past(i_carry_flag))
    else $error("rotate right lost old carry");

  // Same source reaches bit 00 when a right-shift op shifts left
  left_common_a: assert property (
    (left_shift_s ##0 (i_shift_op == BOS_ARITHMETIC_SHIFT_RIGHT))
      |=> operand_q[0] == $past(operand_q[BOS_MSB]))
    else $error("left shift did not use common source");

  // Rotate right op on a left shift still feeds carry into bit 00
  left_carry_a: assert property (
    (left_shift_s ##0 (i_shift_op == BOS_ROTATE_RIGHT))
      |=> operand_q[0] == $past(i_carry_flag))
    else $error("left shift lost common carry source");

  // Disabled upper byte mux drives its whole byte high
  upper_idle_a: assert property (
    low_off_s |=> o_b_operand_bus_n[BOS_MSB:BOS_BYTE_W]
      == BOS_IDLE_BYTE_N)
    else $error("upper byte not forced high");

  // Gated bits 04-07 go high when the low byte is disabled
  mid_gate_a: assert property (
    low_off_s |=> o_b_operand_bus_n[BOS_BYTE_W-1:BOS_NIB_W]
      == BOS_IDLE_NIB_N)
    else $error("bits 04-07 not gated off");

  // Enabled low byte passes bits 00-07 inverted onto the bus
  low_pass_a: assert property (
    low_on_s |=> o_b_operand_bus_n[BOS_BYTE_W-1:0]
      == ~$past(operand_q[BOS_BYTE_W-1:0]))
    else $error("low byte not passed");

  // With the low byte off, the upper select bit has no effect
  upper_ignored_a: assert property (
    (low_off_s ##0 leg.upper_byte_select ##0 leg.plus_one_inhibit_n)
      |=> o_b_operand_bus_n == {BOS_IDLE_BYTE_N, BOS_IDLE_NIB_N,
      BOS_PLUS_ONE_NIB_N})
    else $error("upper select leaked into constant one");

  // Uninhibited constant one puts the +1 pattern on the low nibble
  plus_low_a: assert property (
    (low_off_s ##0 leg.plus_one_inhibit_n)
      |=> o_b_operand_bus_n[BOS_NIB_W-1:0] == BOS_PLUS_ONE_NIB_N)
    else $error("low nibble not the constant one");

  // Sign extended high byte is eight copies of bit 07
  sign_upper_a: assert property (
    (low_on_s ##0 !leg.upper_byte_select)
      |=> o_b_operand_bus_n[BOS_MSB:BOS_BYTE_W]
      == {BOS_BYTE_W{~$past(operand_q[BOS_SIGN_BIT])}})
    else $error("high byte not sign extended");

endmodule // bos_operand_shift_register

// ===== hw/bos_pkg.sv
// ====================================================================
// Shared constants and types for the B operand shift register
package bos_pkg;

  // ==================================================================
  // Widths and bit positions
  localparam int BOS_WORD_W = 16;
  localparam int BOS_BYTE_W = 8;
  localparam int BOS_NIB_W = 4;
  localparam int BOS_SIGN_BIT = 7;
  localparam int BOS_LINK_BIT = 8;
  localparam int BOS_MSB = 15;

  // ==================================================================
  // Control store word layout (word width itself is arbitrary)
  localparam int BOS_CS_W = 48;
  localparam int BOS_CS_MODE_UPPER = 4;
  localparam int BOS_CS_MODE_LOWER = 5;
  localparam int BOS_CS_UPPER_BYTE = 14;
  localparam int BOS_CS_LOWER_BYTE = 16;

  // ==================================================================
  // Reset values and fixed bus patterns (bus is active low)
  localparam logic [15:0] BOS_REG_RST = 16'h0000;
  localparam logic [15:0] BOS_BUS_RST_N = 16'hFFFF;
  localparam logic [3:0] BOS_PLUS_ONE_NIB_N = 4'hE;
  localparam logic [3:0] BOS_IDLE_NIB_N = 4'hF;
  localparam logic [7:0] BOS_IDLE_BYTE_N = 8'hFF;

  // ==================================================================
  // Types
  typedef logic [BOS_WORD_W-1:0] bos_word_t;

  typedef enum logic [1:0] {
    BOS_HOLD,
    BOS_SHIFT_RIGHT,
    BOS_SHIFT_LEFT,
    BOS_LOAD
  } bos_reg_op_e;

  typedef enum logic [1:0] {
    BOS_ARITHMETIC_SHIFT_LEFT,
    BOS_ARITHMETIC_SHIFT_RIGHT,
    BOS_ROTATE_LEFT,
    BOS_ROTATE_RIGHT
  } bos_shift_op_e;

  typedef struct packed {
    logic mode_upper;
    logic mode_lower;
  } bos_mode_s;

  typedef struct packed {
    logic upper_byte_select;
    logic lower_byte_enable;
    logic plus_one_inhibit_n;
  } bos_leg_s;

  // ==================================================================
  // Mode pair to register operation
  function automatic bos_reg_op_e bos_decode_op(input bos_mode_s m);
    bos_reg_op_e op;
    op = BOS_HOLD;
    case ({m.mode_upper, m.mode_lower})
      2'b11: op = BOS_LOAD;
      2'b01: op = BOS_SHIFT_RIGHT;
      2'b10: op = BOS_SHIFT_LEFT;
      default: op = BOS_HOLD;
    endcase
    return op;
  endfunction

endpackage

// ===== hw/bos_leg_shaper.sv
`timescale 1ns/1ps
// ====================================================================
// B operand bus shaping: full word, sign-extended low byte, or +1
module bos_leg_shaper
  import bos_pkg::*;
(
  input wire bos_word_t i_reg,
  input wire bos_leg_s i_leg,
  output bos_word_t o_bus_n
);

  logic plus_one_active;
  logic [BOS_BYTE_W-1:0] upper_n;
  logic [BOS_NIB_W-1:0] mid_n;
  logic [BOS_NIB_W-1:0] low_n;

  // Constant one is active, and the upper byte mux disabled, when the low byte control is low
  assign plus_one_active = ~i_leg.lower_byte_enable;

  // Upper byte: forced high when disabled, else word or sign copy
  always_comb
  begin
    if (plus_one_active)
      upper_n = BOS_IDLE_BYTE_N;
    else if (i_leg.upper_byte_select)
      upper_n = ~i_reg[BOS_MSB:BOS_BYTE_W];
    else
      upper_n = {BOS_BYTE_W{~i_reg[BOS_SIGN_BIT]}};
  end

  // Bits 04-07 are plain NAND gates on the low byte enable
  assign mid_n = ~(i_reg[BOS_BYTE_W-1:BOS_NIB_W]
    & {BOS_NIB_W{i_leg.lower_byte_enable}});

  // Low nibble: +1 pattern, idle when inhibited, or register bits
  always_comb
  begin
    if (!plus_one_active)
      low_n = ~i_reg[BOS_NIB_W-1:0];
    else if (i_leg.plus_one_inhibit_n)
      low_n = BOS_PLUS_ONE_NIB_N;
    else
      low_n = BOS_IDLE_NIB_N;
  end

  assign o_bus_n = {upper_n, mid_n, low_n};

endmodule // bos_leg_shaper

// ===== test/bos_cs_model.sv
`timescale 1ns/1ps
// ====================================================================
// Control store model: places mode and leg fields into the word
module bos_cs_model
  import bos_pkg::*;
#(
  parameter int CS_W = BOS_CS_W
)
(
  input wire bos_mode_s i_mode,
  input wire bos_leg_s i_leg,
  input wire logic [CS_W-1:0] i_noise,
  output logic [CS_W-1:0] o_cs_word
);
  // Unused bits carry noise so the design cannot lean on them
  always_comb
  begin
    o_cs_word = i_noise;
    o_cs_word[BOS_CS_MODE_UPPER] = i_mode.mode_upper;
    o_cs_word[BOS_CS_MODE_LOWER] = i_mode.mode_lower;
    o_cs_word[BOS_CS_UPPER_BYTE] = i_leg.upper_byte_select;
    o_cs_word[BOS_CS_LOWER_BYTE] = i_leg.lower_byte_enable;
  end
endmodule // bos_cs_model

// ===== test/b_operand_shift_register_tb.sv
`timescale 1ns/1ps
// ====================================================================
// Bench: drives at falling edge, queues expectations, checks on rise
module b_operand_shift_register_tb;
  import bos_pkg::*;
  typedef struct packed {
    bos_word_t reg_v;
    bos_word_t bus_n;
  } bos_exp_s;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  bos_mode_s mode = '0;
  bos_leg_s leg = '0;
  logic [47:0] noise = '0;
  logic [47:0] cs_word;
  bos_word_t result = '0;
  bos_shift_op_e op = BOS_ARITHMETIC_SHIFT_LEFT;
  logic carry = 1'b0;
  bos_word_t reg_o;
  bos_word_t bus_o;
  bos_word_t mdl = '0;
  bos_exp_s exp_q[$];
  bos_exp_s e;
  logic [31:0] seed = 32'h8FC9D947;
  int miscompares = 0;
  int tests_run = 0;

  always #2.5 i_clk = ~i_clk;

  bos_cs_model bos_cs_model_inst (.i_mode(mode), .i_leg(leg),
    .i_noise(noise), .o_cs_word(cs_word));
  bos_operand_shift_register bos_operand_shift_register_inst (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cs_word(cs_word),
    .i_result_mux(result), .i_shift_op(op), .i_carry_flag(carry),
    .i_plus_one_inhibit_n(leg.plus_one_inhibit_n),
    .o_operand_shift_register(reg_o), .o_b_operand_bus_n(bus_o));

  // ==================================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected bus, active low; inhibit decides the constant one
  function automatic bos_word_t shape_n(bos_word_t r, bos_leg_s l);
    if (l.lower_byte_enable && l.upper_byte_select) return ~r;
    if (l.lower_byte_enable) return ~{{8{r[7]}}, r[7:0]};
    return l.plus_one_inhibit_n ? 16'hFFFE : 16'hFFFF;
  endfunction

  task automatic check(input bos_word_t seen, input bos_word_t want);
    tests_run++;
    if (seen !== want)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen,
        want);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One cycle of stimulus plus its queued expectation
  task automatic step(input logic [1:0] m, input logic [2:0] l,
    input bos_word_t d, input bos_shift_op_e o, input logic c);
    logic ser;
    bos_word_t nxt;
    @(negedge i_clk);
    mode = bos_mode_s'(m);
    leg = bos_leg_s'(l);
    result = d;
    op = o;
    carry = c;
    noise = {rnd(), rnd()};
    ser = (o == BOS_ARITHMETIC_SHIFT_LEFT) ? 1'b0 :
      (o == BOS_ARITHMETIC_SHIFT_RIGHT) ? mdl[15] : c;
    case (m)
      2'b11: nxt = d;
      2'b01: nxt = {ser, mdl[15:9], mdl[8], mdl[7:1]};
      2'b10: nxt = {mdl[14:0], ser};
      default: nxt = mdl;
    endcase
    exp_q.push_back({nxt, shape_n(mdl, bos_leg_s'(l))});
    mdl = nxt;
  endtask

  // Bounded wait until every queued result was seen
  task automatic drain();
    int n;
    // Park the register so the spare cycles below cannot move it
    step(2'b00, leg, result, op, carry);
    for (n = 0; n < 20 && exp_q.size() > 0; n++)
      @(posedge i_clk);
    @(negedge i_clk);
    if (exp_q.size() > 0)
    begin
      miscompares++;
      finish_test();
    end
  endtask

  // ==================================================================
  // Monitor: oldest note against outputs settled after the edge
  always @(posedge i_clk)
  begin
    if (exp_q.size() > 0)
    begin
      #1;
      e = exp_q.pop_front();
      check(reg_o, e.reg_v);
      check(bus_o, e.bus_n);
    end
  end

  // ==================================================================
  // Main sequence
  initial
  begin
    repeat (12) @(negedge i_clk);
    check(reg_o, BOS_REG_RST);
    check(bus_o, BOS_BUS_RST_N);
    i_arst_n = 1'b1;
    // Walk, then every shift op both ways with both carry values
    step(2'b11, 3'b111, 16'h1234, BOS_ARITHMETIC_SHIFT_LEFT, 1'b1);
    step(2'b01, 3'b111, 16'hFFFF, BOS_ARITHMETIC_SHIFT_RIGHT, 1'b1);
    step(2'b00, 3'b111, 16'h0000, BOS_ROTATE_RIGHT, 1'b1);
    for (int i = 0; i < 16; i++)
    begin
      step(2'b11, 3'b110, 16'h8180, BOS_ROTATE_LEFT, 1'b0);
      step({i[0], ~i[0]}, 3'b110, 16'h0000, bos_shift_op_e'(i[2:1]),
        i[3]);
    end
    // Every leg control and inhibit combination on two patterns
    for (int i = 0; i < 16; i++)
      step(2'b11, i[2:0], i[3] ? 16'h7F80 : 16'h807F,
        BOS_ROTATE_RIGHT, 1'b1);
    drain();
    $display("test directed done");
    for (int i = 0; i < 400; i++)
      step(rnd() & 32'h3, rnd() & 32'h7, rnd(),
        bos_shift_op_e'(2'(rnd())), seed[9]);
    drain();
    $display("test random done");
    // Reset in mid-run after a load
    step(2'b11, 3'b111, 16'hA5C3, BOS_ROTATE_LEFT, 1'b1);
    drain();
    i_arst_n = 1'b0;
    @(negedge i_clk);
    check(reg_o, BOS_REG_RST);
    check(bus_o, BOS_BUS_RST_N);
    i_arst_n = 1'b1;
    mdl = BOS_REG_RST;
    step(2'b10, 3'b001, 16'h0000, BOS_ROTATE_LEFT, 1'b1);
    step(2'b00, 3'b110, 16'hFFFF, BOS_ROTATE_LEFT, 1'b0);
    drain();
    $display("test reset done");
    finish_test();
  end
endmodule // b_operand_shift_register_tb
